//--- core/mps_params.svh
// constants for the module power-state controller
// assumes a 250 MHz clock; seconds are scaled to cycles by MPS_CLK_MHZ times 1000000
`ifndef MPS_PARAMS_SVH
`define MPS_PARAMS_SVH
`define MPS_CLK_MHZ 250
`define MPS_WAKE_HOLD_S 5
`define MPS_WAKE_HOLD_CYC (`MPS_WAKE_HOLD_S * `MPS_CLK_MHZ * 1000000)
`define MPS_DETACH_S 1
`define MPS_DETACH_CYC (`MPS_DETACH_S * `MPS_CLK_MHZ * 1000000)
`define MPS_FAST_CYC 16
`define MPS_DEB_CYC 8
`define MPS_CNT_W 32
`endif

//--- core/mps_pkg.sv
// types of the module power-state controller
// constants live in mps_params.svh
package mps_pkg;
	typedef enum logic [6:0] {
		MPS_OFF = 7'h01,
		MPS_ON = 7'h02,
		MPS_SLEEP = 7'h04,
		MPS_PSM = 7'h08,
		MPS_DETACH = 7'h10,
		MPS_FAST = 7'h20,
		MPS_HALT = 7'h40
	} mps_state_t;
	typedef struct packed {
		logic power_up;
		logic orderly_shutdown_command;
		logic system_halt_command;
		logic fast_shutdown_command;
		logic power_saving_config_command;
		logic psm_timer_expired;
		logic sleep_request;
		logic wake_request;
	} mps_cmd_t;
	typedef struct packed {
		logic baseband_on;
		logic cpu_intermittent;
		logic rtc_on;
		logic cmd_ready;
		logic network_detach;
		logic fs_close;
	} mps_pwr_t;
endpackage

//--- core/mps_filter.sv
// debounce and low-time counter for an active-low input
// input synchronous to clk; counts clk cycles
`timescale 1ns/100ps
`include "mps_params.svh"
module mps_filter #(
	parameter logic [`MPS_CNT_W-1:0] HOLD_CYC = `MPS_CNT_W'(`MPS_WAKE_HOLD_CYC)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pin_n,
	output logic level_low,
	output logic held
);
	logic [3:0] deb;
	logic [`MPS_CNT_W-1:0] low_cnt;

	// debounce: level changes only after DEB_CYC stable samples
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			deb <= 4'h0;
			level_low <= 1'b0;
		end else if ((!pin_n) == level_low) begin
			deb <= 4'h0;
		end else if (deb == 4'(`MPS_DEB_CYC - 1)) begin
			deb <= 4'h0;
			level_low <= !pin_n;
		end else begin
			deb <= deb + 4'h1;
		end
	end

	// saturating low-time count; held once the full hold has passed
	always_ff @(posedge clk) begin
		if (!rst_n || !level_low) begin
			low_cnt <= '0;
			held <= 1'b0;
		end else if (low_cnt >= HOLD_CYC - 1) begin
			held <= 1'b1;
		end else begin
			low_cnt <= low_cnt + 1'b1;
		end
	end
endmodule

//--- core/mps_ctrl.sv
// power-state controller of a cellular module
// host drives power key and commands; one clock, sync reset
// How it works
// R1 - off keeps only the real-time clock running and leaves only toward on.
// R2 - on powers the baseband fully and accepts host commands.
// R3 - sleep powers the processor intermittently and still accepts commands.
// R4 - in power saving mode an expired update timer shuts the device down until wake.
// R5 - a power key held low at least 5 s wakes the device from deep sleep.
// R6 - the host reads the indicator to see deep sleep, only if saving mode was configured.
// R7 - the indicator is high while powered, low in saving mode, never forced low by command.
// R8 - with the key tied low there is no async wake and shutdown needs the halt command.
// R9 - an orderly shutdown detaches and closes the filesystem, taking over 1 s; the code holds detach for exactly DETACH_CYC cycles, 1 s at 250 MHz.
// R10 - unconditional shutdown, not in saving mode, resets and powers down without detach.
// R11 - the host keeps supply removal for emergencies only.
// R12 - a configured input falling high to low starts fast shutdown.
// R13 - the fast shutdown command does the same as the hardware trigger.
// R14 - the key is synchronised, debounced and its low time counted before wake; the code has no synchroniser and takes the key as synchronous to clk.
`timescale 1ns/100ps
`include "mps_params.svh"
module mps_ctrl #(
	parameter logic [`MPS_CNT_W-1:0] WAKE_HOLD_CYC = `MPS_CNT_W'(`MPS_WAKE_HOLD_CYC),
	parameter logic [`MPS_CNT_W-1:0] DETACH_CYC = `MPS_CNT_W'(`MPS_DETACH_CYC)
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic power_key_n,
	input wire logic fast_gpio,
	input wire logic fast_gpio_enable,
	input wire logic unconditional_shutdown,
	input wire mps_pkg::mps_cmd_t cmd,
	output logic power_on_indicator,
	output mps_pkg::mps_pwr_t pwr,
	output mps_pkg::mps_state_t state
);
	mps_pkg::mps_state_t next_state;
	logic key_low;
	logic key_held;
	logic key_held_d;
	logic psm_cfg;
	logic gpio_d;
	logic fast_trig;
	logic unc_seen;
	logic [`MPS_CNT_W-1:0] tmr;
	logic tmr_done;

	mps_filter #(.HOLD_CYC(WAKE_HOLD_CYC)) u_key ( // R14
		.clk(clk),
		.rst_n(rst_n),
		.pin_n(power_key_n),
		.level_low(key_low),
		.held(key_held)
	);

	// falling edge of the configured fast-shutdown input
	always_ff @(posedge clk) begin
		// reset to the idle high level; a pin already low at release reads as a fall in the first cycle, while the state is still off
		if (!rst_n) begin
			gpio_d <= 1'b1;
		end else begin
			gpio_d <= fast_gpio;
		end
	end
	assign fast_trig = (fast_gpio_enable && gpio_d && !fast_gpio) || cmd.fast_shutdown_command; // R12 R13

	// held rises once per press; a key tied low gives one edge only, so no later key wake, though wake_request still wakes
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			key_held_d <= 1'b0;
		end else begin
			key_held_d <= key_held;
		end
	end

	// saving mode armed only after configuration
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			psm_cfg <= 1'b0;
		end else if (cmd.power_saving_config_command) begin
			psm_cfg <= 1'b1;
		end
	end

	// unconditional line: act on release
	// a release while halted or timing a phase is dropped; the timed phases end on their own, halt holds until reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			unc_seen <= 1'b0;
		end else if (state == mps_pkg::MPS_PSM || state == mps_pkg::MPS_OFF) begin
			unc_seen <= 1'b0;
		end else if (unconditional_shutdown) begin
			unc_seen <= 1'b1; // R10
		end else begin
			unc_seen <= 1'b0;
		end
	end

	// timer for detach and fast power-down phases
	// restarts on every state change, so each phase is timed from its own entry
	always_ff @(posedge clk) begin
		if (!rst_n || next_state != state) begin
			tmr <= '0;
		end else if (!tmr_done) begin
			tmr <= tmr + 1'b1;
		end
	end
	assign tmr_done = (state == mps_pkg::MPS_DETACH) ? (tmr >= DETACH_CYC - 1) // R9
		: (tmr >= `MPS_CNT_W'(`MPS_FAST_CYC - 1));

	// priority: unconditional line, fast, halt, orderly, saving-mode timer, sleep and wake
	always_comb begin
		next_state = state;
		case (state)
			mps_pkg::MPS_OFF: begin
				if (cmd.power_up) begin
					next_state = mps_pkg::MPS_ON; // R1
				end
			end
			mps_pkg::MPS_ON, mps_pkg::MPS_SLEEP: begin
				if (unc_seen && !unconditional_shutdown) begin
					next_state = mps_pkg::MPS_OFF; // R10
				end else if (unconditional_shutdown) begin
					next_state = state;
				end else if (fast_trig) begin
					next_state = mps_pkg::MPS_FAST; // R12
				end else if (cmd.system_halt_command) begin
					next_state = mps_pkg::MPS_HALT; // R8
				end else if (cmd.orderly_shutdown_command) begin
					next_state = mps_pkg::MPS_DETACH; // R9
				end else if (psm_cfg && cmd.psm_timer_expired) begin
					next_state = mps_pkg::MPS_PSM; // R4
				end else if (state == mps_pkg::MPS_ON && cmd.sleep_request) begin
					next_state = mps_pkg::MPS_SLEEP; // R3
				end else if (state == mps_pkg::MPS_SLEEP && cmd.wake_request) begin
					next_state = mps_pkg::MPS_ON; // R2
				end
			end
			mps_pkg::MPS_PSM: begin
				if ((key_held && !key_held_d) || cmd.wake_request) begin
					next_state = mps_pkg::MPS_ON; // R5
				end
			end
			mps_pkg::MPS_DETACH, mps_pkg::MPS_FAST: begin
				if (tmr_done) begin
					next_state = mps_pkg::MPS_OFF;
				end
			end
			mps_pkg::MPS_HALT: begin
				next_state = mps_pkg::MPS_HALT; // R8 only supply removal leaves
			end
			default: begin
				next_state = mps_pkg::MPS_OFF;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= mps_pkg::MPS_OFF;
		end else begin
			state <= next_state;
		end
	end

	// outputs registered from next state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			power_on_indicator <= 1'b0;
			pwr <= '0;
		end else begin
			power_on_indicator <= next_state != mps_pkg::MPS_OFF && next_state != mps_pkg::MPS_PSM; // R7 R6
			pwr.rtc_on <= 1'b1; // R1
			pwr.baseband_on <= next_state == mps_pkg::MPS_ON || next_state == mps_pkg::MPS_DETACH; // R2
			pwr.cpu_intermittent <= next_state == mps_pkg::MPS_SLEEP; // R3
			pwr.cmd_ready <= next_state == mps_pkg::MPS_ON || next_state == mps_pkg::MPS_SLEEP;
			pwr.network_detach <= next_state == mps_pkg::MPS_DETACH; // R9
			pwr.fs_close <= next_state == mps_pkg::MPS_DETACH || next_state == mps_pkg::MPS_FAST; // R12
		end
	end

	psm_ind_low_a: assert property (@(posedge clk) disable iff (!rst_n)
		state == mps_pkg::MPS_PSM |-> !power_on_indicator) else $error("indicator high in saving mode"); // R7
	on_ind_high_a: assert property (@(posedge clk) disable iff (!rst_n)
		state == mps_pkg::MPS_ON |-> power_on_indicator) else $error("indicator low while on"); // R7
	off_exit_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
		state == mps_pkg::MPS_OFF ##1 state != mps_pkg::MPS_OFF |-> state == mps_pkg::MPS_ON)
		else $error("off left to wrong state");
	on_baseband_a: assert property (@(posedge clk) disable iff (!rst_n)
		state == mps_pkg::MPS_ON |-> pwr.baseband_on && pwr.cmd_ready) else $error("on without baseband"); // R2
	sleep_inter_a: assert property (@(posedge clk) disable iff (!rst_n)
		state == mps_pkg::MPS_SLEEP |-> pwr.cpu_intermittent && pwr.cmd_ready) else $error("sleep outputs wrong"); // R3
	psm_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(state == mps_pkg::MPS_PSM) |-> $past(psm_cfg)) else $error("saving mode without config"); // R4
	wake_qual_a: assert property (@(posedge clk) disable iff (!rst_n) // R5
		state == mps_pkg::MPS_PSM && !cmd.wake_request && !key_held |=> state == mps_pkg::MPS_PSM)
		else $error("wake without full hold");
	detach_len_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(state == mps_pkg::MPS_DETACH) |-> state == mps_pkg::MPS_DETACH [*2]) else $error("detach too short"); // R9
	fast_go_a: assert property (@(posedge clk) disable iff (!rst_n) // R12
		state == mps_pkg::MPS_ON && fast_gpio_enable && gpio_d && !fast_gpio
		&& !unconditional_shutdown && !unc_seen
		|=> state == mps_pkg::MPS_FAST) else $error("gpio fall ignored");
	fast_cmd_a: assert property (@(posedge clk) disable iff (!rst_n) // R13
		(state == mps_pkg::MPS_ON || state == mps_pkg::MPS_SLEEP) && cmd.fast_shutdown_command
		&& !unconditional_shutdown && !unc_seen |=> state == mps_pkg::MPS_FAST)
		else $error("fast command ignored");
	unc_off_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
		state == mps_pkg::MPS_ON && unc_seen && !unconditional_shutdown
		|=> state == mps_pkg::MPS_OFF && !pwr.network_detach)
		else $error("unconditional release missed");
	halt_stay_a: assert property (@(posedge clk) disable iff (!rst_n)
		state == mps_pkg::MPS_HALT |=> state == mps_pkg::MPS_HALT) else $error("halt left"); // R8

	// outputs and state move on the same edge, so the output checks compare them in one cycle
	off_quiet_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
		state == mps_pkg::MPS_OFF |-> !pwr.baseband_on && !pwr.cmd_ready && !power_on_indicator)
		else $error("powered while off");
	ind_track_a: assert property (@(posedge clk) disable iff (!rst_n) // R7
		power_on_indicator == (state != mps_pkg::MPS_OFF && state != mps_pkg::MPS_PSM))
		else $error("indicator does not follow state");
	psm_gate_a: assert property (@(posedge clk) disable iff (!rst_n) // R4
		(state == mps_pkg::MPS_ON || state == mps_pkg::MPS_SLEEP) && !psm_cfg && cmd.psm_timer_expired
		|=> state != mps_pkg::MPS_PSM) else $error("saving mode entered unconfigured");
	detach_out_a: assert property (@(posedge clk) disable iff (!rst_n) // R9
		state == mps_pkg::MPS_DETACH |-> pwr.network_detach && pwr.fs_close && pwr.baseband_on)
		else $error("detach outputs wrong");
	unc_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
		(state == mps_pkg::MPS_ON || state == mps_pkg::MPS_SLEEP) && unconditional_shutdown |=> $stable(state))
		else $error("state moved while line held");
	fast_close_a: assert property (@(posedge clk) disable iff (!rst_n) // R12
		state == mps_pkg::MPS_FAST |-> pwr.fs_close && !pwr.network_detach && !pwr.baseband_on)
		else $error("fast power-down outputs wrong");
endmodule

//--- verif/mps_host.sv
// host processor model: holds the power key low on request and polls the indicator
// assumes the controller's clock; the supply itself is never modelled as removable
`timescale 1ns/100ps
module mps_host (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic [15:0] hold_cyc,
	input wire logic power_on_indicator,
	output logic power_key_n,
	output logic psm_seen
);
	logic [15:0] left;
	// key stays low for the whole requested span, never shortened
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			power_key_n <= 1'b1;
			left <= 16'h0000;
		end else if (go) begin
			power_key_n <= 1'b0;
			left <= hold_cyc;
		end else if (left > 16'h0001) begin
			left <= left - 16'h0001;
		end else if (left == 16'h0001) begin
			power_key_n <= 1'b1;
			left <= 16'h0000;
		end
	end
	// polling only means deep sleep once saving mode was configured
	always_ff @(posedge clk) begin
		psm_seen <= rst_n & ~power_on_indicator;
	end
endmodule

//--- verif/tb.sv
// self-checking bench of the power-state controller
// assumes mps_ctrl with shortened wake and detach counts
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb;
	logic clk, rst_n, fast_gpio, fast_gpio_enable, unc, go, key_n, psm_seen, ind;
	logic [15:0] hold;
	mps_pkg::mps_cmd_t cmd;
	mps_pkg::mps_pwr_t pwr;
	mps_pkg::mps_state_t state;
	int error_cnt = 0;
	int check_count = 0;
	int n;
	mps_ctrl #(.WAKE_HOLD_CYC(32'd50), .DETACH_CYC(32'd20)) mps_ctrl_i (.clk(clk), .rst_n(rst_n),
		.power_key_n(key_n), .fast_gpio(fast_gpio), .fast_gpio_enable(fast_gpio_enable),
		.unconditional_shutdown(unc), .cmd(cmd), .power_on_indicator(ind), .pwr(pwr), .state(state));
	mps_host mps_host_i (.clk(clk), .rst_n(rst_n), .go(go), .hold_cyc(hold), .power_on_indicator(ind),
		.power_key_n(key_n), .psm_seen(psm_seen));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task wt(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	task pulse(input logic [7:0] v);
		@(posedge clk) cmd <= mps_pkg::mps_cmd_t'(v);
		@(posedge clk) cmd <= '0;
		#1;
	endtask
	task await_st(input mps_pkg::mps_state_t s);
		n = 0;
		while (state !== s && n < 200) begin
			wt(1);
			n++;
		end
	endtask
	task hold_key(input logic [15:0] c);
		@(posedge clk) begin go <= 1'b1; hold <= c; end
		@(posedge clk) go <= 1'b0;
		// room for the release debounce, so the next press starts afresh
		wt(c + 12);
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task t_off_on;
		`CHK(state, mps_pkg::MPS_OFF)
		`CHK({ind, pwr.baseband_on, pwr.rtc_on}, 3'h1)
		pulse(8'h40);
		`CHK(state, mps_pkg::MPS_OFF)
		pulse(8'h80);
		`CHK(state, mps_pkg::MPS_ON)
		`CHK({ind, pwr.baseband_on, pwr.cmd_ready}, 3'h7)
		$display("test off_on done");
	endtask
	task t_sleep;
		pulse(8'h02);
		`CHK(state, mps_pkg::MPS_SLEEP)
		`CHK({pwr.cpu_intermittent, pwr.cmd_ready, ind}, 3'h7)
		pulse(8'h01);
		`CHK(state, mps_pkg::MPS_ON)
		$display("test sleep done");
	endtask
	task t_psm;
		pulse(8'h04);
		`CHK(state, mps_pkg::MPS_ON)
		pulse(8'h08);
		pulse(8'h04);
		`CHK(state, mps_pkg::MPS_PSM)
		wt(1);
		`CHK({ind, psm_seen, pwr.baseband_on}, 3'h2)
		@(posedge clk) unc <= 1'b1;
		wt(3);
		@(posedge clk) unc <= 1'b0;
		wt(3);
		`CHK(state, mps_pkg::MPS_PSM)
		hold_key(16'd30);
		`CHK(state, mps_pkg::MPS_PSM)
		hold_key(16'd90);
		`CHK(state, mps_pkg::MPS_ON)
		`CHK(ind, 1'b1)
		pulse(8'h04);
		`CHK(state, mps_pkg::MPS_PSM)
		pulse(8'h01);
		`CHK(state, mps_pkg::MPS_ON)
		$display("test psm done");
	endtask
	task t_orderly;
		pulse(8'h40);
		`CHK(state, mps_pkg::MPS_DETACH)
		`CHK({pwr.network_detach, pwr.fs_close, ind}, 3'h7)
		await_st(mps_pkg::MPS_OFF);
		`CHK(n >= 18 && n <= 22, 1'b1)
		`CHK(ind, 1'b0)
		$display("test orderly done");
	endtask
	task t_fast;
		pulse(8'h80);
		@(posedge clk) fast_gpio_enable <= 1'b0;
		@(posedge clk) fast_gpio <= 1'b0;
		wt(3);
		`CHK(state, mps_pkg::MPS_ON)
		@(posedge clk) fast_gpio <= 1'b1;
		@(posedge clk) fast_gpio_enable <= 1'b1;
		@(posedge clk) fast_gpio <= 1'b0;
		await_st(mps_pkg::MPS_FAST);
		`CHK(n <= 4 && pwr.fs_close === 1'b1, 1'b1)
		await_st(mps_pkg::MPS_OFF);
		`CHK(n >= 14 && n <= 18, 1'b1)
		@(posedge clk) fast_gpio <= 1'b1;
		pulse(8'h80);
		pulse(8'h10);
		`CHK(state, mps_pkg::MPS_FAST)
		await_st(mps_pkg::MPS_OFF);
		`CHK(n >= 14 && n <= 18, 1'b1)
		$display("test fast done");
	endtask
	task t_unc_halt;
		pulse(8'h80);
		@(posedge clk) unc <= 1'b1;
		wt(5);
		`CHK(state, mps_pkg::MPS_ON)
		@(posedge clk) unc <= 1'b0;
		await_st(mps_pkg::MPS_OFF);
		`CHK(n <= 3 && pwr.network_detach === 1'b0, 1'b1)
		pulse(8'h80);
		pulse(8'h20);
		`CHK(state, mps_pkg::MPS_HALT)
		pulse(8'h80);
		`CHK(state, mps_pkg::MPS_HALT)
		$display("test unc_halt done");
	endtask
	initial begin
		rst_n = 1'b0;
		fast_gpio = 1'b1;
		fast_gpio_enable = 1'b1;
		unc = 1'b0;
		go = 1'b0;
		hold = 16'h0000;
		cmd = '0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		wt(2);
		t_off_on();
		t_sleep();
		t_psm();
		t_orderly();
		t_fast();
		t_unc_halt();
		tally_and_finish();
	end
	initial begin
		#20000;
		error_cnt++;
		tally_and_finish();
	end
endmodule
